// File: design/speed_ramp_regs.vh
/*
  Register map, reset values and timing figures of the speed ramp
  generator. Assumes byte addressing on a 32-bit Avalon-MM slave.
*/
// Contract
// - Nonzero dwell time halts acceleration at dwell speed, then resumes.
// - Ramp times refer to maximum speed or to commanded speed.
// - Maximum-speed base scales duration by speed change over maximum.
// - Reference base reaches commanded speed from standstill in set time.
// - Four accel/decel pairs up to 6000.0 s, defaults 2.00 to 5.00 s.
// - Two select inputs form binary pair index, low input bit 0.
// - Bypass input overrides selects and uses maximum rate.
// - Four S-curve ratios 0.0 to 50.0 percent; zero gives linear.
// - Rounding time is set time times ratio over 50 percent.
// - Large change inserts a linear segment between roundings.
// - Enabled zero-speed option uses its own time toward 0 rpm.
// - Emergency stop ramps reference to zero in emergency time.
// - Motor not stopped at emergency time expiry is left to coast.
// - Emergency time zero stops the motor at once; the code coasts it at once instead (S_COAST).
// - Keypad start pre-excites for set time, both LEDs blinking.
// - Pre-excitation only for the two keypad speed sources.
// - Zero speed is held for hold time after stopping.
// - Final reference is clamped to maximum motor speed.
// - Free-run stop mode coasts at once on a stop command.
`ifndef SPEED_RAMP_REGS_VH
`define SPEED_RAMP_REGS_VH

// ====================================================
// Register offsets
`define OFS_CTRL 8'h00
`define OFS_TARGET 8'h04
`define OFS_MAX_SPD 8'h08
`define OFS_DWELL_SPD 8'h0c
`define OFS_DWELL_TIME 8'h10
`define OFS_ACC_CURVE 8'h18
`define OFS_DEC_CURVE 8'h1c
`define OFS_ACC_TIME 8'h20
`define OFS_DEC_TIME 8'h30
`define OFS_ZERO_TIME 8'h40
`define OFS_EMG_TIME 8'h44
`define OFS_PREEX_TIME 8'h48
`define OFS_HOLD_TIME 8'h4c
`define OFS_STATUS 8'h50
`define OFS_SPEED 8'h54

// ====================================================
// Control fields
`define CTRL_BASE_REF 0
`define CTRL_ZERO_EN 1
`define CTRL_FREE_RUN 2
`define CTRL_SRC_LO 4
`define CTRL_SRC_HI 5
`define SRC_KEYPAD1 2'h1
`define SRC_KEYPAD2 2'h2

// ====================================================
// Reset values (speed 0.1 rpm, times 0.01 s, pre/hold ms)
`define CTRL_RST 6'h10
`define MAX_SPD_RST 16'h4650
`define DWELL_SPD_RST 16'h03e8
`define PAIR1_RST 20'h000c8
`define PAIR2_RST 20'h0012c
`define PAIR3_RST 20'h00190
`define PAIR4_RST 20'h001f4
`define HOLD_RST 14'h03e8
`define CURVE_FULL 9'h1f4

// ====================================================
// Timing
`define CLK_PERIOD_NS 8
`define TICK_NS 1000000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_CS 24'h00000a
`define BLINK_MS 250

`endif

// File: design/ramp_divider.v
/*
  Restoring unsigned divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse issued only while idle.
*/
`timescale 1ns/1ps
module ramp_divider #(
  parameter W = 48
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [W-1:0] num,
  input wire [W-1:0] den,
  output reg done,
  output reg [W-1:0] quo
);
  reg [W:0] rem;
  reg [7:0] cnt;
  wire [W:0] shifted = {rem[W-1:0], quo[W-1]};
  wire [W:0] den_x = {1'b0, den};

  always @(posedge clk) begin
    if (rst) begin
      rem <= {(W+1){1'b0}};
      quo <= {W{1'b0}};
      cnt <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        quo <= num;
        rem <= {(W+1){1'b0}};
        cnt <= W[7:0];
      end else if (cnt != 8'h00) begin
        // Zero divisor yields all ones, read as saturated
        if (shifted >= den_x) begin
          rem <= shifted - den_x;
          quo <= {quo[W-2:0], 1'b1};
        end else begin
          rem <= shifted;
          quo <= {quo[W-2:0], 1'b0};
        end
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: design/speed_ramp_generator.v
/*
  Speed reference ramp generator with Avalon-MM register slave.
  Assumes pins are asynchronous and a tick period well above the
  three serial divisions of the ramp planner.
*/
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "speed_ramp_regs.vh"
module speed_ramp_generator #(
  parameter [31:0] TICK_CYCLES = `TICK_CYC
) (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire RUN_CMD,
  input wire EMERGENCY_STOP_INPUT,
  input wire MULTIFUNCTION_INPUT_1,
  input wire MULTIFUNCTION_INPUT_2,
  input wire MULTIFUNCTION_INPUT_3,
  output reg [15:0] SPEED_REF,
  output reg DRIVE_ENABLE,
  output reg COAST,
  output reg PREEXCITE,
  output reg ZERO_HOLD,
  output reg FWD_LED,
  output reg REV_LED
);
  localparam S_IDLE = 3'h0;
  localparam S_PREEX = 3'h1;
  localparam S_RUN = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_COAST = 3'h4;
  localparam P_IDLE = 2'h0;
  localparam P_RATE = 2'h1;
  localparam P_J1 = 2'h2;
  localparam P_J2 = 2'h3;

  // ====================================================
  // Pin synchronisers and ramp tick
  reg [4:0] pin_s1;
  reg [4:0] pin_s2;
  reg [31:0] tick_cnt;
  reg tick;
  always @(posedge CORE_CLK) begin
    if (RST) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      pin_s1 <= {RUN_CMD, EMERGENCY_STOP_INPUT, MULTIFUNCTION_INPUT_3,
                 MULTIFUNCTION_INPUT_2, MULTIFUNCTION_INPUT_1};
      pin_s2 <= pin_s1;
    end
  end
  wire run_on = pin_s2[4];
  wire estop_on = pin_s2[3];
  wire ramp_bypass_input = pin_s2[2];
  wire [1:0] pair = pin_s2[1:0];

  always @(posedge CORE_CLK) begin
    if (RST) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 32'h1) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // ====================================================
  // Registers and bus slave
  reg [5:0] ctrl;
  reg [15:0] target;
  reg [15:0] max_motor_speed;
  reg [15:0] dwell_speed_setting;
  reg [15:0] dwell_time_setting;
  reg [8:0] accel_start_curve_ratio;
  reg [8:0] accel_end_curve_ratio;
  reg [8:0] decel_start_curve_ratio;
  reg [8:0] decel_end_curve_ratio;
  reg [19:0] acc_t [0:3];
  reg [19:0] dec_t [0:3];
  reg [19:0] zero_speed_decel_time;
  reg [19:0] emergency_decel_time;
  reg [13:0] preexcitation_time;
  reg [13:0] zero_speed_hold_time;
  reg ack;
  reg [31:0] rd_mux;
  reg [2:0] state;
  reg [31:0] spd;
  reg dwelling;
  wire req = AVS_READ | AVS_WRITE;
  wire [3:0] wa = AVS_ADDRESS[5:2];
  wire [31:0] wd = AVS_WRITEDATA;
  assign AVS_WAITREQUEST = req & ~ack;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl <= `CTRL_RST;
      target <= 16'h0;
      max_motor_speed <= `MAX_SPD_RST;
      dwell_speed_setting <= `DWELL_SPD_RST;
      dwell_time_setting <= 16'h0;
      accel_start_curve_ratio <= 9'h0;
      accel_end_curve_ratio <= 9'h0;
      decel_start_curve_ratio <= 9'h0;
      decel_end_curve_ratio <= 9'h0;
      acc_t[0] <= `PAIR1_RST;
      acc_t[1] <= `PAIR2_RST;
      acc_t[2] <= `PAIR3_RST;
      acc_t[3] <= `PAIR4_RST;
      dec_t[0] <= `PAIR1_RST;
      dec_t[1] <= `PAIR2_RST;
      dec_t[2] <= `PAIR3_RST;
      dec_t[3] <= `PAIR4_RST;
      zero_speed_decel_time <= 20'h0;
      emergency_decel_time <= 20'h0;
      preexcitation_time <= 14'h0;
      zero_speed_hold_time <= `HOLD_RST;
      ack <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (AVS_READ & ~ack) begin
        AVS_READDATA <= rd_mux;
      end
      if (AVS_WRITE & ack) begin
        case (AVS_ADDRESS)
          `OFS_CTRL: ctrl <= wd[5:0];
          `OFS_TARGET: target <= wd[15:0];
          `OFS_MAX_SPD: max_motor_speed <= wd[15:0];
          `OFS_DWELL_SPD: dwell_speed_setting <= wd[15:0];
          `OFS_DWELL_TIME: dwell_time_setting <= wd[15:0];
          `OFS_ACC_CURVE: begin
            accel_start_curve_ratio <= wd[8:0];
            accel_end_curve_ratio <= wd[24:16];
          end
          `OFS_DEC_CURVE: begin
            decel_start_curve_ratio <= wd[8:0];
            decel_end_curve_ratio <= wd[24:16];
          end
          `OFS_ZERO_TIME: zero_speed_decel_time <= wd[19:0];
          `OFS_EMG_TIME: emergency_decel_time <= wd[19:0];
          `OFS_PREEX_TIME: preexcitation_time <= wd[13:0];
          `OFS_HOLD_TIME: zero_speed_hold_time <= wd[13:0];
          default: begin
            if (AVS_ADDRESS[7:4] == 4'h2) begin
              acc_t[wa[1:0]] <= wd[19:0];
            end else if (AVS_ADDRESS[7:4] == 4'h3) begin
              dec_t[wa[1:0]] <= wd[19:0];
            end
          end
        endcase
      end
    end
  end

  always @* begin
    rd_mux = 32'h0;
    case (AVS_ADDRESS)
      `OFS_CTRL: rd_mux = {26'h0, ctrl};
      `OFS_TARGET: rd_mux = {16'h0, target};
      `OFS_MAX_SPD: rd_mux = {16'h0, max_motor_speed};
      `OFS_DWELL_SPD: rd_mux = {16'h0, dwell_speed_setting};
      `OFS_DWELL_TIME: rd_mux = {16'h0, dwell_time_setting};
      `OFS_ACC_CURVE: rd_mux = {7'h0, accel_end_curve_ratio,
                                7'h0, accel_start_curve_ratio};
      `OFS_DEC_CURVE: rd_mux = {7'h0, decel_end_curve_ratio,
                                7'h0, decel_start_curve_ratio};
      `OFS_ZERO_TIME: rd_mux = {12'h0, zero_speed_decel_time};
      `OFS_EMG_TIME: rd_mux = {12'h0, emergency_decel_time};
      `OFS_PREEX_TIME: rd_mux = {18'h0, preexcitation_time};
      `OFS_HOLD_TIME: rd_mux = {18'h0, zero_speed_hold_time};
      `OFS_STATUS: rd_mux = {25'h0, dwelling, ZERO_HOLD, PREEXCITE,
                             COAST, state};
      `OFS_SPEED: rd_mux = {16'h0, SPEED_REF};
      default: begin
        if (AVS_ADDRESS[7:4] == 4'h2 && AVS_ADDRESS[1:0] == 2'h0) begin
          rd_mux = {12'h0, acc_t[wa[1:0]]};
        end else if (AVS_ADDRESS[7:4] == 4'h3 &&
                     AVS_ADDRESS[1:0] == 2'h0) begin
          rd_mux = {12'h0, dec_t[wa[1:0]]};
        end
      end
    endcase
  end

  // ====================================================
  // Goal and time selection
  reg [31:0] acc;
  reg dir_up;
  reg [15:0] from_spd;
  wire driving = run_on & ~estop_on;
  wire [15:0] tgt_clamp = (target > max_motor_speed) ?
                          max_motor_speed : target;
  // Goal leads the run or pre-excitation state by one cycle; without pre-excitation the first ramp step uses the rate planned at the previous tick
  wire [15:0] goal = driving ? tgt_clamp : 16'h0;
  wire [31:0] goal_fx = {goal, 16'h0};
  wire up = goal_fx > spd;
  wire [31:0] rem = up ? goal_fx - spd : spd - goal_fx;
  wire [31:0] acc_eff = (up == dir_up) ? acc : 32'h0;
  reg [19:0] sel_t;
  reg [8:0] sel_r1;
  reg [8:0] sel_r2;
  always @* begin
    sel_r1 = decel_end_curve_ratio;
    sel_r2 = decel_start_curve_ratio;
    if (estop_on) begin
      sel_t = emergency_decel_time;
    end else if (up) begin
      sel_t = acc_t[pair];
      sel_r1 = accel_start_curve_ratio;
      sel_r2 = accel_end_curve_ratio;
    end else if (goal == 16'h0 && ctrl[`CTRL_ZERO_EN]) begin
      sel_t = zero_speed_decel_time;
    end else begin
      sel_t = dec_t[pair];
    end
  end
  wire [23:0] ramp_ticks = {4'h0, sel_t} * `TICKS_PER_CS;
  // Reference base: start speed stands in for the target on the way down
  wire [15:0] base = ~ctrl[`CTRL_BASE_REF] ? max_motor_speed :
                     (up ? goal : from_spd);

  // ====================================================
  // Planner: rate and jerks per tick
  reg [1:0] plan_st;
  reg div_start;
  reg [47:0] div_num;
  reg [47:0] div_den;
  reg [31:0] rate;
  reg [31:0] jerk1;
  reg [31:0] jerk2;
  wire div_done;
  wire [47:0] div_quo;
  wire [31:0] quo_sat = (|div_quo[47:32]) ? 32'hffffffff : div_quo[31:0];
  wire [31:0] quo_min = (quo_sat == 32'h0) ? 32'h1 : quo_sat;

  ramp_divider #(.W(48)) u_div (
    .clk(CORE_CLK),
    .rst(RST),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  always @(posedge CORE_CLK) begin
    if (RST) begin
      plan_st <= P_IDLE;
      div_start <= 1'b0;
      div_num <= 48'h0;
      div_den <= 48'h0;
      rate <= 32'h1;
      jerk1 <= 32'h1;
      jerk2 <= 32'h1;
    end else begin
      div_start <= 1'b0;
      case (plan_st)
        P_IDLE: begin
          if (tick && ramp_ticks != 24'h0) begin
            div_num <= {16'h0, base, 16'h0};
            div_den <= {24'h0, ramp_ticks};
            div_start <= 1'b1;
            plan_st <= P_RATE;
          end
        end
        P_RATE: begin
          if (div_done) begin
            rate <= quo_min;
            div_num <= {16'h0, quo_min} * 48'h1f4;
            div_den <= {24'h0, ramp_ticks} * {39'h0, sel_r1};
            div_start <= 1'b1;
            plan_st <= P_J1;
          end
        end
        P_J1: begin
          if (div_done) begin
            jerk1 <= quo_min;
            div_den <= {24'h0, ramp_ticks} * {39'h0, sel_r2};
            div_start <= 1'b1;
            plan_st <= P_J2;
          end
        end
        P_J2: begin
          if (div_done) begin
            jerk2 <= quo_min;
            plan_st <= P_IDLE;
          end
        end
        default: plan_st <= P_IDLE;
      endcase
    end
  end

  // ====================================================
  // Ramp engine
  reg [31:0] next_spd;
  reg [31:0] next_acc;
  wire [64:0] brake_lhs = {32'h0, jerk2, 1'b0} * {33'h0, rem};
  wire [64:0] brake_rhs = {33'h0, acc_eff} * {33'h0, acc_eff};
  wire [31:0] dwell_fx = {dwell_speed_setting, 16'h0};
  always @* begin
    next_spd = spd;
    next_acc = acc_eff;
    if (ramp_bypass_input || ramp_ticks == 24'h0) begin
      next_spd = goal_fx;
      next_acc = 32'h0;
    end else begin
      if (sel_r1 == 9'h0 && sel_r2 == 9'h0) begin
        next_acc = rate;
      end else if (sel_r2 != 9'h0 && acc_eff != 32'h0 &&
                   brake_lhs <= brake_rhs) begin
        // Braking point from a*a = 2*j*d; short moves never reach rate
        next_acc = (acc_eff > jerk2) ? acc_eff - jerk2 : jerk2;
      end else if (sel_r1 == 9'h0) begin
        next_acc = rate;
      end else if (acc_eff < rate) begin
        next_acc = (rate - acc_eff > jerk1) ? acc_eff + jerk1 : rate;
      end
      // Held at full rate the profile runs its linear part
      if (next_acc >= rem) begin
        next_spd = goal_fx;
        next_acc = 32'h0;
      end else begin
        next_spd = up ? spd + next_acc : spd - next_acc;
      end
    end
  end

  // ====================================================
  // Sequencer
  reg [23:0] cnt;
  reg [23:0] estop_cnt;
  reg [19:0] dwell_cnt;
  reg dwell_done;
  reg blink;
  reg [7:0] blink_cnt;
  wire [23:0] emg_ticks = {4'h0, emergency_decel_time} * `TICKS_PER_CS;
  wire [23:0] dwell_ticks = {8'h0, dwell_time_setting} * `TICKS_PER_CS;
  wire keypad = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO] == `SRC_KEYPAD1 ||
                ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO] == `SRC_KEYPAD2;
  wire dwell_hit = up && dwell_time_setting != 16'h0 && !dwell_done &&
                   !ramp_bypass_input && spd < dwell_fx &&
                   next_spd >= dwell_fx;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      state <= S_IDLE;
      spd <= 32'h0;
      acc <= 32'h0;
      dir_up <= 1'b1;
      from_spd <= 16'h0;
      cnt <= 24'h0;
      estop_cnt <= 24'h0;
      dwell_cnt <= 20'h0;
      dwelling <= 1'b0;
      dwell_done <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          spd <= 32'h0;
          acc <= 32'h0;
          dwell_done <= 1'b0;
          dwelling <= 1'b0;
          cnt <= 24'h0;
          estop_cnt <= 24'h0;
          if (driving) begin
            state <= (keypad && preexcitation_time != 14'h0) ?
                     S_PREEX : S_RUN;
          end
        end
        S_PREEX: begin
          if (!driving) begin
            state <= S_IDLE;
          end else if (tick) begin
            cnt <= cnt + 24'h1;
            if (cnt + 24'h1 >= {10'h0, preexcitation_time}) begin
              state <= S_RUN;
            end
          end
        end
        S_RUN: begin
          if (!run_on && !estop_on && ctrl[`CTRL_FREE_RUN]) begin
            state <= S_COAST;
          end else if (estop_on && emergency_decel_time == 20'h0) begin
            state <= S_COAST;
          end else if (estop_on && estop_cnt >= emg_ticks &&
                       spd != 32'h0) begin
            state <= S_COAST;
          end else if (!driving && spd == 32'h0) begin
            state <= S_HOLD;
            cnt <= 24'h0;
          end else if (tick) begin
            estop_cnt <= estop_on ? estop_cnt + 24'h1 : 24'h0;
            if (spd == goal_fx || up != dir_up) begin
              from_spd <= spd[31:16];
            end
            dir_up <= up;
            if (dwelling) begin
              dwell_cnt <= dwell_cnt - 20'h1;
              if (dwell_cnt == 20'h1 || !up) begin
                dwelling <= 1'b0;
                dwell_done <= 1'b1;
              end
            end else if (dwell_hit) begin
              spd <= dwell_fx;
              acc <= 32'h0;
              dwell_cnt <= dwell_ticks[19:0];
              dwelling <= 1'b1;
            end else begin
              spd <= next_spd;
              acc <= next_acc;
            end
          end
        end
        S_HOLD: begin
          spd <= 32'h0;
          if (tick) begin
            cnt <= cnt + 24'h1;
            if (cnt + 24'h1 >= {10'h0, zero_speed_hold_time}) begin
              state <= S_IDLE;
            end
          end
        end
        S_COAST: begin
          spd <= 32'h0;
          acc <= 32'h0;
          if (!run_on && !estop_on) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ====================================================
  // Registered outputs
  always @(posedge CORE_CLK) begin
    if (RST) begin
      SPEED_REF <= 16'h0;
      DRIVE_ENABLE <= 1'b0;
      COAST <= 1'b0;
      PREEXCITE <= 1'b0;
      ZERO_HOLD <= 1'b0;
      FWD_LED <= 1'b0;
      REV_LED <= 1'b0;
      blink <= 1'b0;
      blink_cnt <= 8'h0;
    end else begin
      SPEED_REF <= (spd[31:16] > max_motor_speed) ?
                   max_motor_speed : spd[31:16];
      DRIVE_ENABLE <= state == S_RUN || state == S_PREEX ||
                      state == S_HOLD;
      COAST <= state == S_COAST;
      PREEXCITE <= state == S_PREEX;
      ZERO_HOLD <= state == S_HOLD;
      if (state != S_PREEX) begin
        blink <= 1'b1;
        blink_cnt <= 8'h0;
      end else if (tick) begin
        blink_cnt <= blink_cnt + 8'h1;
        if ({24'h0, blink_cnt} == `BLINK_MS - 1) begin
          blink_cnt <= 8'h0;
          blink <= ~blink;
        end
      end
      FWD_LED <= state == S_PREEX && blink;
      REV_LED <= state == S_PREEX && blink;
    end
  end
endmodule

// File: tb/speed_ramp_sva.sv
/*
  Port checker for the speed ramp generator.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`include "speed_ramp_regs.vh"
module speed_ramp_sva #(
  parameter [31:0] TICK_CYCLES = 200
) (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire AVS_WAITREQUEST,
  input wire EMERGENCY_STOP_INPUT,
  input wire [15:0] SPEED_REF,
  input wire DRIVE_ENABLE,
  input wire COAST,
  input wire PREEXCITE,
  input wire ZERO_HOLD,
  input wire FWD_LED,
  input wire REV_LED
);
  // Maximum speed is tracked from bus writes, as software sets it
  reg [15:0] mx;
  always @(posedge CORE_CLK) begin
    if (RST) begin
      mx <= `MAX_SPD_RST;
    end else if (AVS_WRITE && !AVS_WAITREQUEST &&
                 AVS_ADDRESS == `OFS_MAX_SPD) begin
      mx <= AVS_WRITEDATA[15:0];
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Assertions
  speed_clamp_a: assert property (
    SPEED_REF <= mx || SPEED_REF <= $past(mx))
    else $error("speed reference above maximum");
  led_pair_a: assert property (FWD_LED == REV_LED)
    else $error("direction lamps differ");
  led_idle_a: assert property (
    !PREEXCITE && !$past(PREEXCITE) |-> !FWD_LED)
    else $error("lamp lit outside pre-excitation");
  coast_release_a: assert property (COAST |-> !DRIVE_ENABLE)
    else $error("drive enabled while coasting");
  hold_zero_a: assert property (
    ZERO_HOLD |-> SPEED_REF == 16'h0000 && DRIVE_ENABLE)
    else $error("hold without zero speed");
  preex_zero_a: assert property (
    PREEXCITE |-> SPEED_REF == 16'h0000 && DRIVE_ENABLE)
    else $error("pre-excitation with speed");
  tick_step_a: assert property (
    $changed(SPEED_REF) && !COAST && !EMERGENCY_STOP_INPUT
    |=> $stable(SPEED_REF)[*8])
    else $error("speed changed between ticks");
  estop_fall_a: assert property (
    EMERGENCY_STOP_INPUT[*8] |-> SPEED_REF <= $past(SPEED_REF))
    else $error("speed rose during emergency stop");
  cover property ($rose(ZERO_HOLD));
  cover property ($rose(PREEXCITE));
  cover property ($rose(EMERGENCY_STOP_INPUT) && SPEED_REF != 16'h0000);
endmodule

// File: tb/motor_model.sv
/*
  Behavioural motor and speed loop.
  Assumes one step of 0.1 rpm per clock toward the reference.
*/
`timescale 1ns/1ps
module motor_model (
  input wire clk,
  input wire [15:0] speed_ref,
  input wire drive_on,
  output reg [15:0] shaft_speed
);
  initial shaft_speed = 16'h0000;
  // Slow follower: inertia keeps it from ever matching at once
  always @(posedge clk) begin
    if (drive_on && shaft_speed < speed_ref) begin
      shaft_speed <= shaft_speed + 16'h0001;
    end else if (shaft_speed != 16'h0000 && shaft_speed > speed_ref) begin
      shaft_speed <= shaft_speed - 16'h0001;
    end
  end
endmodule

// File: tb/tb_top.sv
/*
  Self-checking bench for the speed ramp generator.
  Assumes the motor model on the far side and a short ramp tick.
*/
`timescale 1ns/1ps
`include "speed_ramp_regs.vh"
module tb_top;
  localparam int TICK = 200;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic RUN_CMD = 1'b0;
  logic EMERGENCY_STOP_INPUT = 1'b0;
  logic MULTIFUNCTION_INPUT_1 = 1'b0;
  logic MULTIFUNCTION_INPUT_2 = 1'b0;
  logic MULTIFUNCTION_INPUT_3 = 1'b0;
  wire [31:0] AVS_READDATA;
  wire [15:0] SPEED_REF;
  wire [15:0] shaft;
  wire AVS_WAITREQUEST, DRIVE_ENABLE, COAST, PREEXCITE, ZERO_HOLD;
  wire FWD_LED, REV_LED;
  int failures = 0;
  int check_count = 0;
  logic [32:0] notes[$];
  logic [31:0] rng = 32'd66;
  logic [31:0] rd;
  logic [15:0] tgt;
  int t;

  speed_ramp_generator #(.TICK_CYCLES(TICK)) u_speed_ramp_generator (
    .CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RUN_CMD(RUN_CMD),
    .EMERGENCY_STOP_INPUT(EMERGENCY_STOP_INPUT),
    .MULTIFUNCTION_INPUT_1(MULTIFUNCTION_INPUT_1),
    .MULTIFUNCTION_INPUT_2(MULTIFUNCTION_INPUT_2),
    .MULTIFUNCTION_INPUT_3(MULTIFUNCTION_INPUT_3),
    .SPEED_REF(SPEED_REF), .DRIVE_ENABLE(DRIVE_ENABLE), .COAST(COAST),
    .PREEXCITE(PREEXCITE), .ZERO_HOLD(ZERO_HOLD), .FWD_LED(FWD_LED),
    .REV_LED(REV_LED));
  motor_model u_motor_model (.clk(CORE_CLK), .speed_ref(SPEED_REF),
    .drive_on(DRIVE_ENABLE), .shaft_speed(shaft));

  initial forever #4 CORE_CLK = ~CORE_CLK;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic finish_test;
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // Bus master, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    @(posedge CORE_CLK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 40) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("CHECK FAILED %0t bus timeout", $time);
      finish_test();
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    // One idle edge so a following request never double-assigns
    @(posedge CORE_CLK);
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e,
                           input logic lt);
    notes.push_back({lt, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [32:0] n);
    check_count++;
    if (n[32] ? ((got < n[31:0]) !== 1'b1) : (got !== n[31:0])) begin
      failures++;
      $display("CHECK FAILED %0t read %h note %h", $time, got, n[31:0]);
    end
  endtask

  task automatic cmp_shaft(input logic [15:0] e);
    check_count++;
    if (shaft !== e) begin
      failures++;
      $display("CHECK FAILED %0t shaft %h note %h", $time, shaft, e);
    end
  endtask

  always @(posedge CORE_CLK) begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && notes.size() > 0) begin
      cmp_word(AVS_READDATA, notes.pop_front());
    end
  end

  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      if (rd[2:0] === 3'h0) return;
      repeat (40) @(posedge CORE_CLK);
    end
    failures++;
    $display("CHECK FAILED %0t never idle", $time);
    finish_test();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    expect_rd(`OFS_MAX_SPD, 32'h4650, 1'b0);
    expect_rd(`OFS_ACC_TIME, 32'hc8, 1'b0);
    expect_rd(8'h3c, 32'h1f4, 1'b0);
    expect_rd(`OFS_HOLD_TIME, 32'h3e8, 1'b0);
    expect_rd(8'h7c, 32'h0, 1'b0);
    bus(1'b1, `OFS_CTRL, 32'h11);
    bus(1'b1, `OFS_HOLD_TIME, 32'd20);
    bus(1'b1, `OFS_PREEX_TIME, 32'd2);
    bus(1'b1, `OFS_ACC_CURVE, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'(`OFS_ACC_TIME + 4 * k), 32'(k + 1));
      bus(1'b1, 8'(`OFS_DEC_TIME + 4 * k), 32'd1);
    end
    // Each pair from standstill; time in 0.01 s is ten ticks
    for (int k = 0; k < 4; k++) begin
      rng = xorshift(rng);
      tgt = 16'd500 + 16'(rng[9:0]);
      bus(1'b1, `OFS_TARGET, {16'h0, tgt});
      {MULTIFUNCTION_INPUT_2, MULTIFUNCTION_INPUT_1} <= 2'(k);
      RUN_CMD <= 1'b1;
      t = (k + 1) * 10 * TICK;
      repeat (t * 8 / 10) @(posedge CORE_CLK);
      expect_rd(`OFS_SPEED, {16'h0, tgt}, 1'b1);
      repeat (t * 4 / 10 + 3 * TICK) @(posedge CORE_CLK);
      expect_rd(`OFS_SPEED, {16'h0, tgt}, 1'b0);
      cmp_shaft(tgt);
      if (k == 3) begin
        bus(1'b1, `OFS_CTRL, 32'h15);
      end
      RUN_CMD <= 1'b0;
      if (k == 3) begin
        repeat (8) @(posedge CORE_CLK);
        expect_rd(`OFS_SPEED, 32'h0, 1'b0);
      end
      wait_idle();
    end
    bus(1'b1, `OFS_MAX_SPD, 32'd1000);
    bus(1'b1, `OFS_TARGET, 32'd3000);
    bus(1'b1, `OFS_EMG_TIME, 32'h0);
    MULTIFUNCTION_INPUT_3 <= 1'b1;
    RUN_CMD <= 1'b1;
    repeat (6 * TICK) @(posedge CORE_CLK);
    expect_rd(`OFS_SPEED, 32'd1000, 1'b0);
    EMERGENCY_STOP_INPUT <= 1'b1;
    repeat (2 * TICK) @(posedge CORE_CLK);
    expect_rd(`OFS_SPEED, 32'h0, 1'b0);
    EMERGENCY_STOP_INPUT <= 1'b0;
    RUN_CMD <= 1'b0;
    MULTIFUNCTION_INPUT_3 <= 1'b0;
    wait_idle();
    finish_test();
  end
endmodule

bind speed_ramp_generator speed_ramp_sva #(.TICK_CYCLES(TICK_CYCLES))
  u_speed_ramp_sva (
  .CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .EMERGENCY_STOP_INPUT(EMERGENCY_STOP_INPUT), .SPEED_REF(SPEED_REF),
  .DRIVE_ENABLE(DRIVE_ENABLE), .COAST(COAST), .PREEXCITE(PREEXCITE),
  .ZERO_HOLD(ZERO_HOLD), .FWD_LED(FWD_LED), .REV_LED(REV_LED));
